// >>> common/hbp_map.svh
`ifndef HBP_MAP_SVH
`define HBP_MAP_SVH

`define HBP_DATA_W 32
`define HBP_ADDR_W 10
`define HBP_CLK_NS 4
`define HBP_HOST_BUS_CLOCK_HALF_NS 64
`define HBP_HOST_BUS_CLOCK_HALF (`HBP_HOST_BUS_CLOCK_HALF_NS / `HBP_CLK_NS)
`define HBP_SETTLE 8
`define HBP_GAP 8
`define HBP_STRAP_HOLD 3

`define HBP_REG_CTRL 8'h00
`define HBP_REG_ADDR 8'h04
`define HBP_REG_WDATA 8'h08
`define HBP_REG_RDATA 8'h0C
`define HBP_REG_STATE 8'h10
`define HBP_REG_IRQ_STATUS 8'h14
`define HBP_REG_IRQ_MASK 8'h18

`define HBP_CTRL_GO 0
`define HBP_CTRL_WRITE 1
`define HBP_CTRL_SYNC 2
`define HBP_CTRL_INTCLK 3
`define HBP_CTRL_POL 4
`define HBP_CTRL_RESET 5

`define HBP_EV_DONE 0
`define HBP_EV_INT 1
`define HBP_EV_WAKE 2

`define HBP_CTRL_RESET_VAL 6'h00
`define HBP_MASK_RESET_VAL 3'h0

`endif

// >>> common/hbp_pkg.sv
package hbp_pkg;

  typedef enum logic [1:0] {
    W32,
    W16,
    W8,
    W_BAD
  } width_t;

  typedef enum logic [1:0] {
    D_IDLE,
    D_REQ,
    D_DONE
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE,
    H_DRIVE,
    H_SETTLE,
    H_WAIT,
    H_GAP
  } host_state_t;

endpackage : hbp_pkg

// >>> common/host_bus_if.sv
`timescale 1ns/100ps
interface host_bus_if;
  logic cs_n;
  logic wr_n;
  logic oe_n;
  logic host_bus_clock;
  logic [9:0] addr;
  logic [31:0] host_data_o;
  logic [3:0] host_data_oe;
  logic [31:0] dev_data_o;
  logic [3:0] dev_data_oe;
  logic wait_o;
  logic wait_oe;
  logic int_oe;
  logic wake_oe;
  logic [31:0] data;
  logic wait_lvl;
  logic int_n;
  logic wake_event_n;

  // lanes resolve with pull-ups; open-drain pins only pull low
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (dev_data_oe[i])
        data[8*i +: 8] = dev_data_o[8*i +: 8];
      else if (host_data_oe[i])
        data[8*i +: 8] = host_data_o[8*i +: 8];
      else
        data[8*i +: 8] = 8'hFF;
    end
  end
  assign wait_lvl = wait_oe ? wait_o : 1'b1;
  assign int_n = ~int_oe;
  assign wake_event_n = ~wake_oe;

  modport device (
    input cs_n, wr_n, oe_n, host_bus_clock, addr, data,
    output dev_data_o, dev_data_oe, wait_o, wait_oe, int_oe, wake_oe
  );
  modport host (
    input data, wait_lvl, int_n, wake_event_n,
    output cs_n, wr_n, oe_n, host_bus_clock, addr, host_data_o,
    output host_data_oe
  );
endinterface : host_bus_if

// >>> design/sync2.sv
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_q <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : sync2

// >>> design/hbp_device.sv
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "hbp_map.svh"

// What this block does
// - reset floats outputs, aborts access, clears state
// - host holds select low whole access
// - selected access with write strobe low writes
// - drive data only in read with enable low
// - hold-off asserted until data ready, strap polarity
// - interrupt event pulls interrupt pin low
// - wake event pulls wake pin low
// - decode timing, clock source, hold-off polarity straps
// - order data bytes per byte-order straps
// - bus width from straps, narrow uses low lanes
// - internal clock: never power down transceiver
// - internal clock forces asynchronous host timing
// - address stable; sampled at sync edge or select
// - drop low address bits per bus width
module hbp_device
  import hbp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  host_bus_if.device bus,
  input wire logic bus_timing_strap,
  input wire logic clock_source_strap,
  input wire logic hold_off_polarity_strap,
  input wire logic byte_order_strap_0,
  input wire logic byte_order_strap_1,
  input wire logic bus_width_strap_1,
  input wire logic bus_width_strap_0,
  output logic [9:0] core_addr,
  output logic [31:0] core_wdata,
  output logic core_write,
  output logic core_read,
  input wire logic [31:0] core_rdata,
  input wire logic core_ready,
  input wire logic irq_req,
  input wire logic wake_req,
  output logic cfg_valid,
  output logic cfg_sync_mode,
  output logic cfg_internal_clock,
  output logic [1:0] cfg_width
);

  logic [6:0] strap_s;
  logic [3:0] ctl_s;
  logic [9:0] addr_s;
  logic [31:0] data_s;
  logic [6:0] strap_q;
  logic [1:0] hold_cnt_q;
  logic latched_q;
  logic cs_d_q;
  logic clk_d_q;
  dev_state_t state_q;
  logic write_q;
  logic [31:0] rdata_q;
  logic [3:0] data_oe_q;
  logic int_oe_q;
  logic wake_oe_q;
  width_t width;
  logic sync_mode;
  logic cfg_ok;
  logic start;
  logic cs_s;
  logic wr_s;
  logic oe_s;
  logic clk_s;
  logic pol;
  logic [1:0] order_code;
  logic [3:0] lanes;

  // byte order within the used width; every code undoes itself
  function automatic logic [31:0] reorder(
    input logic [31:0] d,
    input logic [1:0] code,
    input width_t w
  );
    logic [31:0] r;
    r = d;
    if (w == W32)
    begin
      unique case (code)
        2'b00: r = d;
        2'b01: r = {d[23:16], d[31:24], d[7:0], d[15:8]};
        2'b10: r = {d[15:0], d[31:16]};
        2'b11: r = {d[7:0], d[15:8], d[23:16], d[31:24]};
      endcase
    end
    else if (w == W16)
    begin
      r = {16'h0000, d[15:0]};
      if (code[0])
        r = {16'h0000, d[7:0], d[15:8]};
    end
    else
      r = {24'h000000, d[7:0]};
    return r;
  endfunction : reorder

  // byte address presented to the core
  function automatic logic [9:0] core_address(
    input logic [9:0] a,
    input width_t w
  );
    logic [9:0] r;
    unique case (w)
      W32: r = {a[9:2], 2'b00};
      W16: r = {a[9:1], 1'b0};
      default: r = a;
    endcase
    return r;
  endfunction : core_address

  sync2 #(.W(7), .INIT(7'h00)) u_strap_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({bus_timing_strap, clock_source_strap, hold_off_polarity_strap,
        byte_order_strap_0, byte_order_strap_1,
        bus_width_strap_1, bus_width_strap_0}),
    .q(strap_s)
  );

  sync2 #(.W(4), .INIT(4'hE)) u_ctl_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({bus.cs_n, bus.wr_n, bus.oe_n, bus.host_bus_clock}),
    .q(ctl_s)
  );

  sync2 #(.W(42), .INIT(42'h000_0000_0000)) u_pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({bus.addr, bus.data}),
    .q({addr_s, data_s})
  );

  assign {cs_s, wr_s, oe_s, clk_s} = ctl_s;

  // straps caught a few cycles after reset release, then held
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hold_cnt_q <= 2'h0;
      latched_q <= 1'b0;
      strap_q <= 7'h00;
    end
    else if (!latched_q)
    begin
      hold_cnt_q <= hold_cnt_q + 2'h1;
      if (hold_cnt_q == 2'(`HBP_STRAP_HOLD))
      begin
        latched_q <= 1'b1;
        strap_q <= strap_s;
      end
    end
  end

  // timing code 0,1 is reserved; width 11 is reserved
  assign sync_mode = !strap_q[6] && !strap_q[5];
  assign pol = strap_q[4];
  assign order_code = strap_q[3:2];
  assign width = width_t'(strap_q[1:0]);
  assign cfg_ok = latched_q && !(!strap_q[6] && strap_q[5])
                  && width != W_BAD;
  assign lanes = (width == W32) ? 4'hF :
                 (width == W16) ? 4'h3 : 4'h1;

  assign cfg_valid = cfg_ok;
  assign cfg_sync_mode = sync_mode;
  assign cfg_internal_clock = strap_q[5];
  assign cfg_width = strap_q[1:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cs_d_q <= 1'b1;
      clk_d_q <= 1'b0;
    end
    else
    begin
      cs_d_q <= cs_s;
      clk_d_q <= clk_s;
    end
  end

  // access starts at first bus clock rise or at seen select fall
  assign start = cfg_ok && !cs_s &&
                 (sync_mode ? (clk_s && !clk_d_q)
                            : (cs_d_q && !cs_s));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= D_IDLE;
      write_q <= 1'b0;
      core_addr <= 10'h000;
      core_wdata <= 32'h0000_0000;
      core_write <= 1'b0;
      core_read <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      core_write <= 1'b0;
      core_read <= 1'b0;
      unique case (state_q)
        D_IDLE:
          if (start)
          begin
            write_q <= !wr_s;
            core_addr <= core_address(addr_s, width);
            core_wdata <= reorder(data_s, order_code, width);
            core_write <= !wr_s;
            core_read <= wr_s;
            state_q <= D_REQ;
          end
        D_REQ:
          if (cs_s)
            state_q <= D_IDLE;
          else if (core_ready)
          begin
            if (!write_q)
              rdata_q <= reorder(core_rdata, order_code, width);
            state_q <= D_DONE;
          end
        D_DONE:
          if (cs_s)
            state_q <= D_IDLE;
      endcase
    end
  end

  // data lanes on only while selected read with output enable low
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      data_oe_q <= 4'h0;
    else if (state_q == D_DONE && !write_q && !cs_s && !oe_s)
      data_oe_q <= lanes;
    else
      data_oe_q <= 4'h0;
  end

  assign bus.dev_data_o = rdata_q;
  assign bus.dev_data_oe = data_oe_q;

  // hold-off driven while selected, released once a write is done or read data is driven
  assign bus.wait_oe = cfg_ok && !cs_s;
  assign bus.wait_o = (state_q == D_DONE && (write_q || |data_oe_q))
                      ? !pol : pol;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      int_oe_q <= 1'b0;
      wake_oe_q <= 1'b0;
    end
    else
    begin
      int_oe_q <= irq_req;
      wake_oe_q <= wake_req;
    end
  end

  // pins only ever pulled low; pull-ups give the high level
  assign bus.int_oe = int_oe_q;
  assign bus.wake_oe = wake_oe_q;

endmodule : hbp_device

// >>> design/hbp_host.sv
`timescale 1ns/100ps
`include "hbp_map.svh"

module hbp_host
  import hbp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  output logic dev_reset_n,
  host_bus_if.host bus
);

  logic [5:0] ctrl_q;
  logic [9:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [2:0] irq_status_q;
  logic [2:0] irq_mask_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  host_state_t state_q;
  logic [3:0] cnt_q;
  logic [4:0] div_q;
  logic bclk_q;
  logic [2:0] pin_s;
  logic [31:0] data_s;
  logic sync_mode;
  logic fall_tick;
  logic step;
  logic go;
  logic busy;
  logic ready_seen;
  logic [2:0] ev;
  logic addr_ph;

  sync2 #(.W(3), .INIT(3'h7)) u_pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({bus.wait_lvl, bus.int_n, bus.wake_event_n}),
    .q(pin_s)
  );

  sync2 #(.W(32), .INIT(32'h0000_0000)) u_data_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(bus.data),
    .q(data_s)
  );

  // synchronous timing only with the external clock
  assign sync_mode = ctrl_q[`HBP_CTRL_SYNC]
                     && !ctrl_q[`HBP_CTRL_INTCLK];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_q <= 5'h00;
      bclk_q <= 1'b0;
    end
    else if (div_q == 5'(`HBP_HOST_BUS_CLOCK_HALF - 1))
    begin
      div_q <= 5'h00;
      bclk_q <= !bclk_q;
    end
    else
      div_q <= div_q + 5'h01;
  end

  assign fall_tick = bclk_q && div_q == 5'(`HBP_HOST_BUS_CLOCK_HALF - 1);
  assign step = sync_mode ? fall_tick : 1'b1;
  assign bus.host_bus_clock = sync_mode ? bclk_q : 1'b0;

  assign busy = state_q != H_IDLE;
  assign ready_seen = pin_s[2] != ctrl_q[`HBP_CTRL_POL];
  assign addr_ph = hsel && htrans[1] && hready;
  assign go = wr_pend_q && wr_addr_q == `HBP_REG_CTRL
              && hwdata[`HBP_CTRL_GO] && !busy;

  // pin changes only just after a bus clock fall in sync timing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= H_IDLE;
      cnt_q <= 4'h0;
      bus.cs_n <= 1'b1;
      bus.wr_n <= 1'b1;
      bus.oe_n <= 1'b1;
      bus.addr <= 10'h000;
      bus.host_data_o <= 32'h0000_0000;
      bus.host_data_oe <= 4'h0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      unique case (state_q)
        H_IDLE:
          if (go)
            state_q <= H_DRIVE;
        H_DRIVE:
          if (step)
          begin
            bus.cs_n <= 1'b0;
            bus.addr <= addr_q;
            bus.wr_n <= !ctrl_q[`HBP_CTRL_WRITE];
            bus.oe_n <= ctrl_q[`HBP_CTRL_WRITE];
            bus.host_data_o <= wdata_q;
            bus.host_data_oe <= {4{ctrl_q[`HBP_CTRL_WRITE]}};
            cnt_q <= 4'h0;
            state_q <= H_SETTLE;
          end
        H_SETTLE:
        begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'(`HBP_SETTLE - 1))
            state_q <= H_WAIT;
        end
        H_WAIT:
          if (ready_seen && step)
          begin
            if (!ctrl_q[`HBP_CTRL_WRITE])
              rdata_q <= data_s;
            bus.cs_n <= 1'b1;
            bus.oe_n <= 1'b1;
            bus.wr_n <= 1'b1;
            bus.host_data_oe <= 4'h0;
            cnt_q <= 4'h0;
            state_q <= H_GAP;
          end
        H_GAP:
        begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'(`HBP_GAP - 1))
            state_q <= H_IDLE;
        end
        default:
          state_q <= H_IDLE;
      endcase
    end
  end

  // register writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= addr_ph && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= `HBP_CTRL_RESET_VAL;
      addr_q <= 10'h000;
      wdata_q <= 32'h0000_0000;
      irq_mask_q <= `HBP_MASK_RESET_VAL;
    end
    else if (wr_pend_q && !busy)
    begin
      unique case (wr_addr_q)
        `HBP_REG_CTRL: ctrl_q <= {hwdata[5:1], 1'b0};
        `HBP_REG_ADDR: addr_q <= hwdata[9:0];
        `HBP_REG_WDATA: wdata_q <= hwdata;
        `HBP_REG_IRQ_MASK: irq_mask_q <= hwdata[2:0];
        default: ;
      endcase
    end
    else if (wr_pend_q && wr_addr_q == `HBP_REG_IRQ_MASK)
      irq_mask_q <= hwdata[2:0];
  end

  // events stick until written one; a new event wins over the clear
  assign ev[`HBP_EV_DONE] = state_q == H_GAP
                            && cnt_q == 4'(`HBP_GAP - 1);
  assign ev[`HBP_EV_INT] = !pin_s[1];
  assign ev[`HBP_EV_WAKE] = !pin_s[0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_status_q <= 3'h0;
    else if (wr_pend_q && wr_addr_q == `HBP_REG_IRQ_STATUS)
      irq_status_q <= (irq_status_q & ~hwdata[2:0]) | ev;
    else
      irq_status_q <= irq_status_q | ev;
  end

  assign irq = |(irq_status_q & irq_mask_q);
  assign dev_reset_n = !ctrl_q[`HBP_CTRL_RESET];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_ph && !hwrite)
    begin
      unique case (haddr[7:0])
        `HBP_REG_CTRL: hrdata <= {26'h0, ctrl_q};
        `HBP_REG_ADDR: hrdata <= {22'h0, addr_q};
        `HBP_REG_WDATA: hrdata <= wdata_q;
        `HBP_REG_RDATA: hrdata <= rdata_q;
        `HBP_REG_STATE: hrdata <= {29'h0, pin_s[0], pin_s[1], busy};
        `HBP_REG_IRQ_STATUS: hrdata <= {29'h0, irq_status_q};
        `HBP_REG_IRQ_MASK: hrdata <= {29'h0, irq_mask_q};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule : hbp_host

// >>> bench/hbp_chk.sv
`timescale 1ns/100ps
module hbp_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic oe_n,
  input wire logic [3:0] dev_data_oe,
  input wire logic wait_o,
  input wire logic wait_oe,
  input wire logic int_oe,
  input wire logic wake_oe,
  input wire logic int_n,
  input wire logic wake_event_n,
  input wire logic hold_off_polarity_strap,
  input wire logic irq_req,
  input wire logic wake_req,
  input wire logic core_write,
  input wire logic core_read,
  input wire logic core_ready
);
  logic [3:0] cs_hi_q;
  logic [3:0] oe_hi_q;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // cycles since select went high
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cs_hi_q <= 4'hF;
    else if (!cs_n)
      cs_hi_q <= 4'h0;
    else if (cs_hi_q != 4'hF)
      cs_hi_q <= cs_hi_q + 4'h1;
  end

  // cycles since output enable went high
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      oe_hi_q <= 4'hF;
    else if (!oe_n)
      oe_hi_q <= 4'h0;
    else if (oe_hi_q != 4'hF)
      oe_hi_q <= oe_hi_q + 4'h1;
  end

  reset_float_a:
  assert property ($rose(hresetn) |-> dev_data_oe == 4'h0 && !wait_oe
    && !int_oe && !wake_oe) else $error("outputs driven after reset");
  data_read_only_a:
  assert property (|dev_data_oe |-> wr_n && oe_hi_q < 4'h6)
    else $error("data driven outside read");
  wait_in_cycle_a:
  assert property (wait_oe |-> cs_hi_q < 4'h6)
    else $error("hold-off driven outside cycle");
  select_answer_a:
  assert property ($fell(cs_n) |-> ##[1:40] wait_oe)
    else $error("no hold-off after select");
  hold_off_pol_a:
  assert property ($rose(wait_oe) |-> wait_o == hold_off_polarity_strap)
    else $error("hold-off starts at wrong level");
  wait_release_a:
  assert property (core_ready && wait_oe && wait_o == hold_off_polarity_strap
    |-> ##[1:2] wait_o != hold_off_polarity_strap)
    else $error("hold-off not released");
  int_follow_a:
  assert property ($changed(irq_req) |=> int_oe == $past(irq_req)
    && int_n == !int_oe) else $error("interrupt pin not following");
  wake_follow_a:
  assert property (wake_req [*2] |-> wake_oe && !wake_event_n)
    else $error("wake pin not pulled low");
  pins_released_a:
  assert property (!irq_req && !wake_req ##1 !irq_req && !wake_req
    |-> !int_oe && !wake_oe) else $error("open drain pin held low");
  write_strobe_a:
  assert property (core_write |-> !cs_n && !wr_n)
    else $error("write outside selected write");
  read_strobe_a:
  assert property (core_read |-> !cs_n && wr_n)
    else $error("read outside selected read");
endmodule : hbp_chk

// >>> bench/host_bus_control_and_straps_test.sv
`timescale 1ns/100ps
`include "hbp_map.svh"
`define CHK(a, e) check_eq(32'(a), 32'(e))
module host_bus_control_and_straps_test
  import hbp_pkg::*;
;
  logic hclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, core_rdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic bus_timing_strap = 1'b0, clock_source_strap = 1'b0;
  logic hold_off_polarity_strap = 1'b0, byte_order_strap_0 = 1'b0;
  logic byte_order_strap_1 = 1'b0, bus_width_strap_1 = 1'b0;
  logic bus_width_strap_0 = 1'b0, irq_req = 1'b0, wake_req = 1'b0;
  logic core_ready = 1'b0;
  logic [31:0] hrdata, core_wdata, seen_wdata, q, mask;
  logic [9:0] core_addr, seen_addr;
  logic hreadyout, hresp, irq, dev_reset_n, core_write, core_read;
  logic cfg_valid, cfg_sync_mode, cfg_internal_clock, pol;
  logic [1:0] cfg_width;
  logic [5:0] mode;
  int n_mismatch = 0, checked = 0, n_wr = 0, n_rd = 0, dly = 0, cnt = 0;
  int m, k;
  wire logic dev_rst_n = rst_n & dev_reset_n;

  host_bus_if host_bus_if_i ();
  wire logic [1:0] pins_n = {host_bus_if_i.int_n,
    host_bus_if_i.wake_event_n};

  hbp_device hbp_device_i (.hclk(hclk), .hresetn(dev_rst_n),
    .bus(host_bus_if_i), .bus_timing_strap(bus_timing_strap),
    .clock_source_strap(clock_source_strap),
    .hold_off_polarity_strap(hold_off_polarity_strap),
    .byte_order_strap_0(byte_order_strap_0),
    .byte_order_strap_1(byte_order_strap_1),
    .bus_width_strap_1(bus_width_strap_1),
    .bus_width_strap_0(bus_width_strap_0), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_write(core_write),
    .core_read(core_read), .core_rdata(core_rdata),
    .core_ready(core_ready), .irq_req(irq_req), .wake_req(wake_req),
    .cfg_valid(cfg_valid), .cfg_sync_mode(cfg_sync_mode),
    .cfg_internal_clock(cfg_internal_clock), .cfg_width(cfg_width));

  hbp_host hbp_host_i (.hclk(hclk), .hresetn(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .dev_reset_n(dev_reset_n), .bus(host_bus_if_i));

  hbp_chk hbp_chk_i (.hclk(hclk), .hresetn(dev_rst_n),
    .cs_n(host_bus_if_i.cs_n), .wr_n(host_bus_if_i.wr_n),
    .oe_n(host_bus_if_i.oe_n), .dev_data_oe(host_bus_if_i.dev_data_oe),
    .wait_o(host_bus_if_i.wait_o), .wait_oe(host_bus_if_i.wait_oe),
    .int_oe(host_bus_if_i.int_oe), .wake_oe(host_bus_if_i.wake_oe),
    .int_n(host_bus_if_i.int_n),
    .wake_event_n(host_bus_if_i.wake_event_n),
    .hold_off_polarity_strap(hold_off_polarity_strap),
    .irq_req(irq_req), .wake_req(wake_req), .core_write(core_write),
    .core_read(core_read), .core_ready(core_ready));

  always #2 hclk = ~hclk;

  // core side: one ready pulse dly+2 cycles after each strobe rises
  always @(posedge hclk)
  begin
    core_ready <= (cnt == 1);
    if (core_write === 1'b1 || core_read === 1'b1)
    begin
      seen_addr <= core_addr;
      seen_wdata <= core_wdata;
      n_wr <= n_wr + (core_write === 1'b1);
      n_rd <= n_rd + (core_read === 1'b1);
      cnt <= dly + 1;
    end
    else if (cnt > 0)
      cnt <= cnt - 1;
  end

  task automatic summarize;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask : check_eq

  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      n_mismatch++;
      summarize();
    end
  endtask : wait_ready

  task automatic ahb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask : ahb

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (4) @(posedge hclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask : do_reset

  task automatic set_straps(input logic bt, input logic cs,
    input logic p, input logic [1:0] o, input logic [1:0] w);
    bus_timing_strap <= bt;
    clock_source_strap <= cs;
    hold_off_polarity_strap <= p;
    byte_order_strap_0 <= o[1];
    byte_order_strap_1 <= o[0];
    bus_width_strap_1 <= w[1];
    bus_width_strap_0 <= w[0];
    do_reset();
  endtask : set_straps

  task automatic xfer(input logic wr, input logic [31:0] wd);
    int n;
    ahb(1'b1, `HBP_REG_ADDR, 32'h3FF);
    ahb(1'b1, `HBP_REG_WDATA, wd);
    ahb(1'b1, `HBP_REG_CTRL, {26'h0, mode | {4'h0, wr, 1'b1}});
    repeat (2) @(posedge hclk);
    n = 0;
    do
    begin
      ahb(1'b0, `HBP_REG_STATE, 32'h0);
      n++;
    end
    while (q[0] !== 1'b0 && n < 200);
    if (n >= 200)
    begin
      n_mismatch++;
      summarize();
    end
  endtask : xfer

  function automatic logic [31:0] lane_map(int w, int o, logic [31:0] d);
    if (w == 2)
      return {24'h0, d[7:0]};
    if (w == 1)
      return {16'h0, o[0] ? {d[7:0], d[15:8]} : d[15:0]};
    case (o)
      1: return {d[23:16], d[31:24], d[7:0], d[15:8]};
      2: return {d[15:0], d[31:16]};
      3: return {d[7:0], d[15:8], d[23:16], d[31:24]};
      default: return d;
    endcase
  endfunction : lane_map

  initial
  begin
    do_reset();
    `CHK(host_bus_if_i.data, 32'hFFFFFFFF);
    `CHK(pins_n, 2'b11);
    ahb(1'b0, `HBP_REG_CTRL, 32'h0);
    `CHK(q, 32'h0);
    `CHK({hresp, hreadyout}, 2'b01);
    ahb(1'b1, 8'h1C, 32'hFFFFFFFF);
    ahb(1'b0, 8'h1C, 32'h0);
    `CHK(q, 32'h0);
    for (int c = 0; c < 16; c++)
    begin
      set_straps(c[3], c[2], 1'b0, 2'h0, c[1:0]);
      `CHK(cfg_valid, c[3:2] != 2'b01 && c[1:0] != 2'h3);
      `CHK(cfg_width, c[1:0]);
      if (c[3:2] != 2'b01)
        `CHK({cfg_sync_mode, cfg_internal_clock}, {~c[3], c[2]});
    end
    for (int w = 0; w < 3; w++)
      for (int o = 0; o < 4; o++)
      begin
        k = w * 4 + o;
        m = k % 3;
        pol = o[0] ^ w[0];
        set_straps(m != 0, m == 2, pol, o[1:0], w[1:0]);
        mask = w == 0 ? 32'hFFFFFFFF : w == 1 ? 32'hFFFF : 32'hFF;
        mode = {1'b0, pol, m == 2, m == 0, 2'b00};
        dly = o * 3;
        xfer(1'b1, 32'hA1B2C3D4);
        `CHK(n_wr, k + 1);
        q = w == 0 ? 32'h3FC : w == 1 ? 32'h3FE : 32'h3FF;
        `CHK(seen_addr, q);
        q = lane_map(w, o, 32'hA1B2C3D4);
        `CHK(seen_wdata & mask, q);
        core_rdata <= 32'h5E6F7A8B;
        xfer(1'b0, 32'h0);
        `CHK(n_rd, k + 1);
        ahb(1'b0, `HBP_REG_RDATA, 32'h0);
        `CHK(q, lane_map(w, o, 32'h5E6F7A8B) | ~mask);
      end
    ahb(1'b0, `HBP_REG_IRQ_STATUS, 32'h0);
    `CHK(q[0], 1'b1);
    ahb(1'b1, `HBP_REG_IRQ_STATUS, 32'h7);
    for (int j = 1; j < 3; j++)
    begin
      ahb(1'b1, `HBP_REG_IRQ_MASK, 32'h0);
      irq_req <= (j == 1);
      wake_req <= (j == 2);
      repeat (4) @(posedge hclk);
      `CHK(pins_n, j);
      ahb(1'b0, `HBP_REG_STATE, 32'h0);
      `CHK({irq, q[2:1]}, 3 - j);
      ahb(1'b1, `HBP_REG_IRQ_MASK, 32'(1 << j));
      @(posedge hclk);
      `CHK(irq, 1'b1);
      irq_req <= 1'b0;
      wake_req <= 1'b0;
      repeat (4) @(posedge hclk);
      `CHK(pins_n, 2'b11);
      ahb(1'b1, `HBP_REG_IRQ_STATUS, 32'(1 << j));
      @(posedge hclk);
      `CHK(irq, 1'b0);
    end
    ahb(1'b1, `HBP_REG_CTRL, 32'h20);
    @(posedge hclk);
    `CHK({dev_reset_n, cfg_valid}, 2'b00);
    ahb(1'b1, `HBP_REG_CTRL, 32'h0);
    repeat (8) @(posedge hclk);
    dly = 300;
    ahb(1'b1, `HBP_REG_CTRL, {26'h0, mode | 6'h01});
    repeat (20) @(posedge hclk);
    `CHK(host_bus_if_i.wait_lvl, pol);
    rst_n <= 1'b0;
    irq_req <= 1'b1;
    repeat (2) @(posedge hclk);
    `CHK(host_bus_if_i.data, 32'hFFFFFFFF);
    `CHK({pins_n, host_bus_if_i.wait_lvl}, 3'h7);
    irq_req <= 1'b0;
    do_reset();
    summarize();
  end
endmodule : host_bus_control_and_straps_test
